// ===== rtl/i2c_slave_regs.vh
`ifndef I2C_SLAVE_REGS_VH
`define I2C_SLAVE_REGS_VH

// register offsets on the plain register port
`define BUS_CONFIGURATION_ADDR 8'hd6
`define STATUS_CONTROL_ADDR 8'hd7

// bus_configuration fields
`define CFG_ENABLE_BIT 0
`define CFG_RATE_LO_BIT 2
`define CFG_RATE_HI_BIT 3
`define CFG_STOP_IRQ_ENABLE_BIT 4
`define CFG_PIN_SEL_BIT 6
`define CFG_WRITE_MASK 8'h5d
`define CFG_RESET 8'h00

// sample-rate codes
`define RATE_100K 2'h0
`define RATE_400K 2'h1
`define RATE_50K 2'h2

// status_control fields
`define SCR_BYTE_DONE_BIT 0
`define SCR_LAST_ACK_BIT 1
`define SCR_TRANSMIT_BIT 2
`define SCR_ADDRESS_BIT 3
`define SCR_ACK_OUT_BIT 4
`define SCR_STOP_SEEN_BIT 5
`define SCR_BUS_ERROR_BIT 7
`define SCR_RESET 8'h00

// bits per byte on the serial side
`define BITS_PER_BYTE 4'h8

`endif

// ===== rtl/i2c_slave_config_status.v
// Design decision made here: the address-and-strobe port.
`include "i2c_slave_regs.vh"

// Summary of operation
// - stop interrupt only when stop enable set
// - rate field picks 100K, 400K or 50K sampling
// - pin select zero primary pair, one alternate
// - stop interrupt only on stop flag rising
// - address byte after start raises interrupt
// - disabled block held reset, pins released
// - enable synchronised before reaching internal logic
// - any start restarts address reception
// - any stop returns machine to idle
// - byte end interrupts and stalls clock low
// - status reads harmless, any write releases stall
// - status flags cleared by writing zero
// - misplaced start or stop sets bus error
// - stop flag sticky, clear needs byte done
// - ack-out sent, cleared at next byte done
// - address flag marks address byte
// - transmit bit picks direction, start clears
// - last ack captures ninth bit, start clears
// - byte done after nine or eight bits
// - sample clock from divide-by-2/4/8 tap
// - nack on transmit returns idle on write
module i2c_slave_config_status #(
  parameter ADDR_W = 8
) (
  input wire clk,
  input wire rst,
  input wire [ADDR_W-1:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  output reg [7:0] rdata_ff,
  input wire [7:0] tx_byte,
  output reg [7:0] rx_byte_ff,
  input wire scl_pri_in,
  input wire sda_pri_in,
  input wire scl_alt_in,
  input wire sda_alt_in,
  output reg scl_pri_out_ff,
  output reg sda_pri_out_ff,
  output reg scl_alt_out_ff,
  output reg sda_alt_out_ff,
  output reg scl_pri_oe_ff,
  output reg sda_pri_oe_ff,
  output reg scl_alt_oe_ff,
  output reg sda_alt_oe_ff,
  output reg pins_owned_ff,
  output reg irq_ff
);

  // one-hot slave states
  localparam [6:0] ST_IDLE = 7'b0000001;
  localparam [6:0] ST_RX = 7'b0000010;
  localparam [6:0] ST_RXW = 7'b0000100;
  localparam [6:0] ST_RACK = 7'b0001000;
  localparam [6:0] ST_TX = 7'b0010000;
  localparam [6:0] ST_TACK = 7'b0100000;
  localparam [6:0] ST_TXW = 7'b1000000;

  reg [7:0] cfg_ff;
  reg en_s1_ff;
  reg en_s2_ff;
  reg [2:0] div_ff;
  reg tap_s1_ff;
  reg tap_s2_ff;
  reg tap_d_ff;
  reg tick_d_ff;
  reg [3:0] pin_s1_ff;
  reg [3:0] pin_s2_ff;
  reg scl_q_ff;
  reg scl_p_ff;
  reg sda_q_ff;
  reg sda_p_ff;
  reg [6:0] state_ff;
  reg [3:0] cnt_ff;
  reg [7:0] shift_ff;
  reg fell_ff;
  reg addr_phase_ff;
  reg sda_drv_ff;
  reg scl_hold_ff;
  reg berr_ff;
  reg stop_ff;
  reg ack_ff;
  reg address_ff;
  reg transmit_ff;
  reg lrb_ff;
  reg bd_ff;
  reg tap;
  reg scl_m;
  reg sda_m;

  wire run;
  wire go;
  wire tick;
  wire scl_rise;
  wire scl_fall;
  wire start_ev;
  wire stop_ev;
  wire bd_set;
  wire berr_set;
  wire lrb_cap;
  wire psel;
  wire [7:0] scr_rd;

  assign run = en_s2_ff;
  assign psel = cfg_ff[`CFG_PIN_SEL_BIT];
  // any status_control write continues the transfer
  assign go = wr & (addr == `STATUS_CONTROL_ADDR) & run;

  // configuration register, written regardless of enable
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_ff <= `CFG_RESET;
    end else if (wr && addr == `BUS_CONFIGURATION_ADDR) begin
      cfg_ff <= wdata & `CFG_WRITE_MASK;
    end
  end

  // enable crosses two flops so release is synchronous
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      en_s1_ff <= 1'b0;
      en_s2_ff <= 1'b0;
    end else begin
      en_s1_ff <= cfg_ff[`CFG_ENABLE_BIT];
      en_s2_ff <= en_s1_ff;
    end
  end

  // divider taps, reserved code falls back to the slowest tap
  always @* begin
    case (cfg_ff[`CFG_RATE_HI_BIT:`CFG_RATE_LO_BIT])
      `RATE_400K: tap = div_ff[0];
      `RATE_100K: tap = div_ff[1];
      `RATE_50K: tap = div_ff[2];
      default: tap = div_ff[2];
    endcase
  end

  // divider held in reset while disabled; selected tap resynchronised
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      div_ff <= 3'h0;
      tap_s1_ff <= 1'b0;
      tap_s2_ff <= 1'b0;
      tap_d_ff <= 1'b0;
      tick_d_ff <= 1'b0;
    end else if (!run) begin
      div_ff <= 3'h0;
      tap_s1_ff <= 1'b0;
      tap_s2_ff <= 1'b0;
      tap_d_ff <= 1'b0;
      tick_d_ff <= 1'b0;
    end else begin
      div_ff <= div_ff + 3'h1;
      tap_s1_ff <= tap;
      tap_s2_ff <= tap_s1_ff;
      tap_d_ff <= tap_s2_ff;
      tick_d_ff <= tick;
    end
  end

  assign tick = tap_s2_ff & ~tap_d_ff;

  // pins pass two flops before anything looks at them
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_s1_ff <= 4'hf;
      pin_s2_ff <= 4'hf;
    end else begin
      pin_s1_ff <= {sda_alt_in, scl_alt_in, sda_pri_in, scl_pri_in};
      pin_s2_ff <= pin_s1_ff;
    end
  end

  // route the selected pair into the block
  always @* begin
    scl_m = psel ? pin_s2_ff[2] : pin_s2_ff[0];
    sda_m = psel ? pin_s2_ff[3] : pin_s2_ff[1];
  end

  // sample the lines on the sample clock, keep previous sample
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_q_ff <= 1'b1;
      scl_p_ff <= 1'b1;
      sda_q_ff <= 1'b1;
      sda_p_ff <= 1'b1;
    end else if (tick) begin
      scl_q_ff <= scl_m;
      scl_p_ff <= scl_q_ff;
      sda_q_ff <= sda_m;
      sda_p_ff <= sda_q_ff;
    end
  end

  // bus events are judged once per sample, the cycle after it
  assign scl_rise = tick_d_ff & scl_q_ff & ~scl_p_ff;
  assign scl_fall = tick_d_ff & ~scl_q_ff & scl_p_ff;
  assign start_ev = tick_d_ff & scl_q_ff & scl_p_ff & sda_p_ff & ~sda_q_ff;
  assign stop_ev = tick_d_ff & scl_q_ff & scl_p_ff & ~sda_p_ff & sda_q_ff;
  assign bd_set = ((state_ff == ST_RX) & scl_rise & (cnt_ff == `BITS_PER_BYTE - 4'h1))
                | ((state_ff == ST_TACK) & scl_rise);
  assign lrb_cap = (state_ff == ST_TACK) & scl_rise;
  // start or stop is only legal idle or before a fresh received byte;
  // the clock rise that frames the condition is counted as bit 0, so one rise is still legal
  assign berr_set = (start_ev | stop_ev)
                  & ~((state_ff == ST_IDLE) | ((state_ff == ST_RX) & (cnt_ff <= 4'h1)));

  // slave sequencer: shifting, acknowledge and clock stall
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      fell_ff <= 1'b0;
      addr_phase_ff <= 1'b0;
      sda_drv_ff <= 1'b0;
      scl_hold_ff <= 1'b0;
      rx_byte_ff <= 8'h00;
    end else if (!run || stop_ev) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 4'h0;
      fell_ff <= 1'b0;
      addr_phase_ff <= 1'b0;
      sda_drv_ff <= 1'b0;
      scl_hold_ff <= 1'b0;
      if (!run) begin
        shift_ff <= 8'h00;
        rx_byte_ff <= 8'h00;
      end
    end else if (start_ev) begin
      state_ff <= ST_RX;
      cnt_ff <= 4'h0;
      fell_ff <= 1'b0;
      addr_phase_ff <= 1'b1;
      sda_drv_ff <= 1'b0;
      scl_hold_ff <= 1'b0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          sda_drv_ff <= 1'b0;
          scl_hold_ff <= 1'b0;
        end
        ST_RX: begin
          if (scl_rise) begin
            shift_ff <= {shift_ff[6:0], sda_q_ff};
            cnt_ff <= cnt_ff + 4'h1;
            if (cnt_ff == `BITS_PER_BYTE - 4'h1) begin
              rx_byte_ff <= {shift_ff[6:0], sda_q_ff};
              state_ff <= ST_RXW;
              fell_ff <= 1'b0;
            end
          end
        end
        ST_RXW, ST_TXW: begin
          // stall from the first low phase until software writes
          if (scl_fall) begin
            fell_ff <= 1'b1;
          end
          if (go) begin
            scl_hold_ff <= 1'b0;
            cnt_ff <= 4'h0;
            if (state_ff == ST_RXW) begin
              state_ff <= ST_RACK;
            end else if (lrb_ff) begin
              state_ff <= ST_IDLE;
            end else if (transmit_ff) begin
              state_ff <= ST_TX;
              shift_ff <= tx_byte;
            end else begin
              state_ff <= ST_RX;
            end
          end else if (scl_fall) begin
            scl_hold_ff <= 1'b1;
          end
        end
        ST_RACK: begin
          // ack bit is put out only once the clock is low
          sda_drv_ff <= ack_ff & fell_ff;
          if (scl_fall && !fell_ff) begin
            fell_ff <= 1'b1;
          end else if (scl_fall) begin
            sda_drv_ff <= 1'b0;
            cnt_ff <= 4'h0;
            addr_phase_ff <= 1'b0;
            if (addr_phase_ff && !ack_ff) begin
              state_ff <= ST_IDLE;
            end else if (transmit_ff) begin
              state_ff <= ST_TX;
              shift_ff <= tx_byte;
            end else begin
              state_ff <= ST_RX;
            end
          end
        end
        ST_TX: begin
          sda_drv_ff <= fell_ff & ~shift_ff[7];
          if (scl_rise) begin
            cnt_ff <= cnt_ff + 4'h1;
          end
          if (scl_fall && !fell_ff) begin
            fell_ff <= 1'b1;
          end else if (scl_fall && cnt_ff == `BITS_PER_BYTE) begin
            state_ff <= ST_TACK;
            sda_drv_ff <= 1'b0;
          end else if (scl_fall) begin
            shift_ff <= {shift_ff[6:0], 1'b0};
          end
        end
        ST_TACK: begin
          sda_drv_ff <= 1'b0;
          if (scl_rise) begin
            state_ff <= ST_TXW;
            fell_ff <= 1'b0;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // status and control flags; hardware set wins over a software clear
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      berr_ff <= 1'b0;
      stop_ff <= 1'b0;
      ack_ff <= 1'b0;
      address_ff <= 1'b0;
      transmit_ff <= 1'b0;
      lrb_ff <= 1'b0;
      bd_ff <= 1'b0;
    end else if (!run) begin
      berr_ff <= 1'b0;
      stop_ff <= 1'b0;
      ack_ff <= 1'b0;
      address_ff <= 1'b0;
      transmit_ff <= 1'b0;
      lrb_ff <= 1'b0;
      bd_ff <= 1'b0;
    end else begin
      berr_ff <= (berr_ff & ~(go & ~wdata[`SCR_BUS_ERROR_BIT])) | berr_set;
      stop_ff <= (stop_ff & ~(go & ~wdata[`SCR_STOP_SEEN_BIT] & bd_ff)) | stop_ev;
      address_ff <= (address_ff & ~(go & ~wdata[`SCR_ADDRESS_BIT])) | (bd_set & addr_phase_ff);
      if (bd_set) begin
        ack_ff <= 1'b0;
      end else if (go) begin
        ack_ff <= wdata[`SCR_ACK_OUT_BIT];
      end
      if (start_ev) begin
        transmit_ff <= 1'b0;
        lrb_ff <= 1'b0;
        bd_ff <= 1'b0;
      end else begin
        if (go) begin
          transmit_ff <= wdata[`SCR_TRANSMIT_BIT];
        end
        lrb_ff <= lrb_cap ? sda_q_ff : (lrb_ff & ~(go & ~wdata[`SCR_LAST_ACK_BIT]));
        bd_ff <= (bd_ff & ~(go & ~wdata[`SCR_BYTE_DONE_BIT])) | bd_set;
      end
    end
  end

  // one-cycle interrupt pulse; stop only on a fresh stop flag
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= run & (bd_set | berr_set
              | (stop_ev & ~stop_ff & cfg_ff[`CFG_STOP_IRQ_ENABLE_BIT]));
    end
  end

  // open-drain pins: level is always low, only the enables move
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_pri_out_ff <= 1'b0;
      sda_pri_out_ff <= 1'b0;
      scl_alt_out_ff <= 1'b0;
      sda_alt_out_ff <= 1'b0;
      scl_pri_oe_ff <= 1'b0;
      sda_pri_oe_ff <= 1'b0;
      scl_alt_oe_ff <= 1'b0;
      sda_alt_oe_ff <= 1'b0;
      pins_owned_ff <= 1'b0;
    end else begin
      scl_pri_out_ff <= 1'b0;
      sda_pri_out_ff <= 1'b0;
      scl_alt_out_ff <= 1'b0;
      sda_alt_out_ff <= 1'b0;
      scl_pri_oe_ff <= run & ~psel & scl_hold_ff;
      sda_pri_oe_ff <= run & ~psel & sda_drv_ff;
      scl_alt_oe_ff <= run & psel & scl_hold_ff;
      sda_alt_oe_ff <= run & psel & sda_drv_ff;
      pins_owned_ff <= run;
    end
  end

  assign scr_rd = {berr_ff, 1'b0, stop_ff, ack_ff, address_ff, transmit_ff, lrb_ff, bd_ff};

  // read data for one cycle after the strobe; no read side effects
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_ff <= 8'h00;
    end else if (rd && addr == `BUS_CONFIGURATION_ADDR) begin
      rdata_ff <= cfg_ff;
    end else if (rd && addr == `STATUS_CONTROL_ADDR) begin
      rdata_ff <= scr_rd;
    end else begin
      rdata_ff <= 8'h00;
    end
  end

endmodule

// ===== testbench/i2c_slave_checker_asserts.sv
module i2c_slave_checker #(
  parameter ADDR_W = 8
) (
  input wire clk,
  input wire rst,
  input wire [ADDR_W-1:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  input wire [7:0] rdata_ff,
  input wire scl_pri_out_ff,
  input wire sda_pri_out_ff,
  input wire scl_alt_out_ff,
  input wire sda_alt_out_ff,
  input wire scl_pri_oe_ff,
  input wire sda_pri_oe_ff,
  input wire scl_alt_oe_ff,
  input wire sda_alt_oe_ff,
  input wire pins_owned_ff,
  input wire irq_ff
);
  timeunit 1ns;
  timeprecision 1ns;
  reg [7:0] cfg_ff;
  reg pend_ff;
  wire cfg_wr = wr && addr == 8'hd6;
  wire scr_wr = wr && addr == 8'hd7;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // shadow config and an interrupt not yet answered by a status write
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_ff <= 8'h00;
      pend_ff <= 1'b0;
    end else begin
      if (cfg_wr) begin
        cfg_ff <= wdata & 8'h5d;
      end
      pend_ff <= irq_ff || (pend_ff && !scr_wr);
    end
  end
  a_cfg_readback: assert property (rd && addr == 8'hd6 |=> rdata_ff == cfg_ff) else $error("config readback");
  a_enable_on: assert property ($rose(cfg_ff[0]) |-> ##[1:3] pins_owned_ff) else $error("enable late");
  a_enable_off: assert property ($fell(cfg_ff[0]) |-> ##[1:3] !pins_owned_ff) else $error("disable late");
  a_pins_released: assert property (!pins_owned_ff && !$past(pins_owned_ff) |->
    !(scl_pri_oe_ff || sda_pri_oe_ff || scl_alt_oe_ff || sda_alt_oe_ff)) else $error("pins driven");
  a_pair_select: assert property (!cfg_ff[6] && $stable(cfg_ff[6]) |->
    !(scl_alt_oe_ff || sda_alt_oe_ff)) else $error("alternate pair driven");
  // the hold flop clears on the write edge, the registered enable one clock later
  a_stall_release: assert property (scr_wr && scl_pri_oe_ff |=> ##1 !scl_pri_oe_ff) else $error("stall kept");
  a_stall_cause: assert property ($rose(scl_pri_oe_ff || scl_alt_oe_ff) |-> pend_ff) else $error("stall");
  a_stall_holds: assert property (scl_pri_oe_ff && cfg_ff[0] && !wr && !$past(wr) |=>
    scl_pri_oe_ff) else $error("stall");
  a_level_low: assert property (!(scl_pri_out_ff || sda_pri_out_ff || scl_alt_out_ff || sda_alt_out_ff))
    else $error("pin level not low");
  a_irq_pulse: assert property (irq_ff |=> !irq_ff) else $error("interrupt too long");
  // the main scenarios: an interrupt, a stall on each pair
  cover property (irq_ff);
  cover property ($rose(scl_pri_oe_ff));
  cover property ($rose(scl_alt_oe_ff));
endmodule

bind i2c_slave_config_status i2c_slave_checker #(.ADDR_W(ADDR_W)) chk_u (.clk, .rst, .addr, .wdata, .wr, .rd,
  .rdata_ff, .scl_pri_out_ff, .sda_pri_out_ff, .scl_alt_out_ff, .sda_alt_out_ff,
  .scl_pri_oe_ff, .sda_pri_oe_ff, .scl_alt_oe_ff, .sda_alt_oe_ff, .pins_owned_ff, .irq_ff);

// ===== testbench/i2c_master_model.sv
module i2c_master_model (
  input wire scl_in,
  input wire sda_in,
  output logic scl_drv,
  output logic sda_drv
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HALF = 4000;
  // released at start, the pull-ups hold both lines high
  initial begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
  end
  // raise the clock, waiting while a slave stretches it low
  task automatic rise;
    int n;
    n = 0;
    scl_drv = 1'b1;
    while (scl_in !== 1'b1 && n < 20000) begin
      #100;
      n++;
    end
    #HALF;
  endtask
  // data moves only while the clock is low, else it reads as start or stop
  task automatic clk_bit(input logic b, output logic r);
    sda_drv = b;
    #HALF;
    rise;
    r = sda_in;
    scl_drv = 1'b0;
    #(HALF / 4);
  endtask
  task automatic start;
    sda_drv = 1'b1;
    #HALF;
    rise;
    sda_drv = 1'b0;
    #HALF;
    scl_drv = 1'b0;
    #(HALF / 4);
  endtask
  task automatic stop;
    sda_drv = 1'b0;
    #HALF;
    rise;
    sda_drv = 1'b1;
    #HALF;
  endtask
  // msb first, then the acknowledge clock
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) clk_bit(b[i], r);
    clk_bit(1'b1, ack);
  endtask
  task automatic recv_byte(input logic nack, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) clk_bit(1'b1, b[i]);
    clk_bit(nack, r);
  endtask
endmodule

// ===== testbench/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [7:0] a;
    logic w;
    logic [7:0] d;
    logic [7:0] e;
  } row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] tx_byte = 8'h00;
  logic alt = 1'b0;
  logic [7:0] v;
  logic k;
  int n_mismatch = 0;
  int cmp_count = 0;
  wire [7:0] rdata_ff;
  wire [7:0] rx_byte_ff;
  wire scl_pri_oe_ff, sda_pri_oe_ff, scl_alt_oe_ff, sda_alt_oe_ff, pins_owned_ff, irq_ff, m_scl, m_sda;
  // wired-and with pull-ups; the master sits on the selected pair only
  wire scl_pri_in = (alt | m_scl) & ~scl_pri_oe_ff;
  wire sda_pri_in = (alt | m_sda) & ~sda_pri_oe_ff;
  wire scl_alt_in = (~alt | m_scl) & ~scl_alt_oe_ff;
  wire sda_alt_in = (~alt | m_sda) & ~sda_alt_oe_ff;
  // reset values, access kinds, a reserved rate code, an unmapped place
  row_t rows [6] = '{'{8'hd6, 1'b0, 8'h00, 8'h00}, '{8'hd7, 1'b0, 8'h00, 8'h00}, '{8'hd6, 1'b1, 8'hfe, 8'h5c},
    '{8'hd7, 1'b1, 8'hff, 8'h00}, '{8'h10, 1'b0, 8'h00, 8'h00}, '{8'hd6, 1'b1, 8'h0c, 8'h0c}};
  i2c_slave_config_status dut_u (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata_ff, .tx_byte, .rx_byte_ff,
    .scl_pri_in, .sda_pri_in, .scl_alt_in, .sda_alt_in, .scl_pri_out_ff(), .sda_pri_out_ff(),
    .scl_alt_out_ff(), .sda_alt_out_ff(), .scl_pri_oe_ff, .sda_pri_oe_ff, .scl_alt_oe_ff, .sda_alt_oe_ff,
    .pins_owned_ff, .irq_ff);
  i2c_master_model m_u (.scl_in(alt ? scl_alt_in : scl_pri_in), .sda_in(alt ? sda_alt_in : sda_pri_in),
    .scl_drv(m_scl), .sda_drv(m_sda));
  always #50 clk = ~clk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata_ff, e);
  endtask
  task automatic wait_irq;
    int n;
    n = 0;
    while (irq_ff !== 1'b1 && n < 9000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk({7'h0, irq_ff}, 8'h01);
  endtask
  // software answer to a finished byte: look, let the stall come, look again, write
  task automatic byte_done(input logic [7:0] e, input logic [7:0] wv);
    int n;
    wait_irq;
    rchk(8'hd7, e);
    n = 0;
    while (scl_pri_oe_ff !== 1'b1 && scl_alt_oe_ff !== 1'b1 && n < 2000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk({6'h0, scl_pri_oe_ff, scl_alt_oe_ff}, alt ? 8'h01 : 8'h02);
    rchk(8'hd7, e);
    reg_wr(8'hd7, wv);
  endtask
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // a hang is cut off well beyond the fraction of a millisecond the run needs
  initial begin
    #8000000;
    n_mismatch++;
    complete_run;
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].w) reg_wr(rows[i].a, rows[i].d);
      rchk(rows[i].a, rows[i].e);
    end
    // alternate pair at the slowest rate, select written with enable
    alt = 1'b1;
    reg_wr(8'hd6, 8'h49);
    repeat (3) @(posedge clk);
    #1;
    chk({7'h0, pins_owned_ff}, 8'h01);
    // lines held high meanwhile; three slow sample clocks pass before any traffic
    repeat (24) @(posedge clk);
    fork
      begin
        m_u.start;
        m_u.send_byte(8'ha0, k);
      end
      byte_done(8'h09, 8'h00);
    join
    chk({7'h0, k}, 8'h01);
    m_u.stop;
    reg_wr(8'hd6, 8'h00);
    // primary pair, fast rate, stop interrupt on: write then receive
    alt = 1'b0;
    reg_wr(8'hd6, 8'h15);
    fork
      begin
        m_u.start;
        m_u.send_byte(8'ha0, k);
      end
      byte_done(8'h09, 8'h10);
    join
    chk(rx_byte_ff, 8'ha0);
    chk({7'h0, k}, 8'h00);
    fork
      m_u.send_byte(8'h5a, k);
      byte_done(8'h01, 8'h00);
    join
    chk(rx_byte_ff, 8'h5a);
    chk({7'h0, k}, 8'h01);
    fork
      m_u.stop;
      wait_irq;
    join
    rchk(8'hd7, 8'h20);
    reg_wr(8'hd7, 8'h00);
    rchk(8'hd7, 8'h20);
    // read transfer ending in a master nack
    tx_byte <= 8'hc3;
    fork
      begin
        m_u.start;
        m_u.send_byte(8'ha1, k);
        m_u.recv_byte(1'b1, v);
      end
      begin
        byte_done(8'h29, 8'h34);
        byte_done(8'h27, 8'h00);
      end
    join
    chk(v, 8'hc3);
    fork
      m_u.stop;
      wait_irq;
    join
    rchk(8'hd7, 8'h20);
    // standard rate, a start in mid byte, then a fresh address
    reg_wr(8'hd6, 8'h11);
    fork
      begin
        m_u.start;
        for (int i = 0; i < 3; i++) m_u.clk_bit(1'b1, k);
        m_u.start;
      end
      wait_irq;
    join
    rchk(8'hd7, 8'ha0);
    fork
      m_u.send_byte(8'ha0, k);
      byte_done(8'ha9, 8'h00);
    join
    m_u.stop;
    reg_wr(8'hd6, 8'h00);
    repeat (3) @(posedge clk);
    #1;
    chk({7'h0, pins_owned_ff}, 8'h00);
    rchk(8'hd7, 8'h00);
    complete_run;
  end
endmodule
